// ===== core/wsc_comparator.sv
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
module wsc_comparator #(
  parameter int NUM_SCALES = 4,
  parameter int SRC_W = 2,
  parameter int TICK_DIV = wsc_pkg::TICK_CYCLES,
  parameter int LEAD_SHIFT = 2
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [5:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic [NUM_SCALES*32-1:0] weight_i,
  input wire logic [NUM_SCALES-1:0] sample_valid_i,
  input wire logic [NUM_SCALES-1:0] standstill_i,
  input wire logic batch_run_i,
  input wire logic batch_done_i,
  output logic feed_o,
  output logic satisfied_o
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Saturate to the documented weight range
  function automatic logic [23:0] sat_val(input logic [31:0] v);
    return (v > {8'h00, wsc_pkg::VAL_MAX}) ? wsc_pkg::VAL_MAX : v[23:0];
  endfunction : sat_val

  // ****************************************
  // Declarations
  // ****************************************
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [1:0] dir_ff;
  logic [1:0] cut_ff;
  logic [1:0] kind_ff;
  logic batch_mode_ff;
  logic [SRC_W-1:0] src_ff;
  logic [23:0] target_ff;
  logic [23:0] half_win_ff;
  logic [23:0] deadband_ff;
  logic [23:0] cutoff_ff;
  logic [23:0] gain_ff;
  logic [15:0] settle_ff;
  logic [15:0] interval_ff;
  logic [23:0] tol_ff;
  logic skip_ff;
  logic done_ff;
  logic sat_ff;
  logic feed_ff;
  logic run_d_ff;
  logic [31:0] prev_w_ff;
  logic [15:0] tmr_cnt_ff;
  logic [15:0] bat_cnt_ff;
  logic [15:0] lrn_cnt_ff;
  logic [15:0] settle_cnt_ff;
  logic signed [33:0] cap_w_ff;
  wsc_pkg::wsc_learn_t lstate_ff;
  wsc_pkg::wsc_learn_t nxt_lstate;
  logic tick;
  logic acc;
  logic wr;
  logic [31:0] wr_word;
  logic [31:0] rd_mux;
  logic [31:0] w_raw;
  logic smp;
  logic still;
  logic signed [33:0] w;
  logic signed [33:0] w_eval;
  logic signed [33:0] tgt;
  logic signed [33:0] cut;
  logic signed [33:0] hw;
  logic signed [33:0] db;
  logic in_win;
  logic met;
  logic rearm;
  logic nxt_sat;
  logic signed [33:0] err;
  logic signed [58:0] prod;
  logic signed [33:0] new_cut;
  logic out_tol;
  logic lrn_apply;
  logic lrn_skip;
  logic lrn_start;

  // ****************************************
  // Tick source
  // ****************************************
  wsc_tick_div #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // Request held by master; one wait cycle then acknowledge
  assign acc = (read_i | write_i) & ~wait_ff;
  assign wr = acc & write_i;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~((read_i | write_i) & wait_ff);
    end
  end

  // Read data registered during the wait cycle, stable at the ack edge
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0;
    end else if (read_i & wait_ff) begin
      rdata_ff <= rd_mux;
    end
  end

  assign waitrequest_o = wait_ff;
  assign readdata_o = rdata_ff;

  always_comb begin
    rd_mux = 32'h0;
    case (address_i)
      wsc_pkg::OFF_CTRL: begin
        rd_mux[wsc_pkg::CTRL_DIR_POS +: 2] = dir_ff;
        rd_mux[wsc_pkg::CTRL_CUT_POS +: 2] = cut_ff;
        rd_mux[wsc_pkg::CTRL_KIND_POS +: 2] = kind_ff;
        rd_mux[wsc_pkg::CTRL_BATCH_POS] = batch_mode_ff;
        rd_mux[wsc_pkg::CTRL_SRC_POS +: SRC_W] = src_ff;
      end
      wsc_pkg::OFF_TARGET: rd_mux = {8'h00, target_ff};
      wsc_pkg::OFF_HALF_WIN: rd_mux = {8'h00, half_win_ff};
      wsc_pkg::OFF_DEADBAND: rd_mux = {8'h00, deadband_ff};
      wsc_pkg::OFF_CUTOFF: rd_mux = {8'h00, cutoff_ff};
      wsc_pkg::OFF_GAIN: rd_mux = {8'h00, gain_ff};
      wsc_pkg::OFF_SETTLE: rd_mux = {16'h0000, settle_ff};
      wsc_pkg::OFF_INTERVAL: rd_mux = {16'h0000, interval_ff};
      wsc_pkg::OFF_TOL_WIN: rd_mux = {8'h00, tol_ff};
      wsc_pkg::OFF_STATUS: begin
        rd_mux[wsc_pkg::ST_SAT] = sat_ff;
        rd_mux[wsc_pkg::ST_FEED] = feed_ff;
        rd_mux[wsc_pkg::ST_INWIN] = in_win;
        rd_mux[wsc_pkg::ST_BUSY] = (lstate_ff != wsc_pkg::LS_IDLE);
        rd_mux[wsc_pkg::ST_SKIP] = skip_ff;
        rd_mux[wsc_pkg::ST_DONE] = done_ff;
      end
      wsc_pkg::OFF_WEIGHT: rd_mux = w_raw;
      default: rd_mux = 32'h0;
    endcase
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_comb begin
    wr_word = 32'h0;
    case (address_i)
      wsc_pkg::OFF_CTRL: wr_word = be_merge(rd_mux, writedata_i, byteenable_i);
      wsc_pkg::OFF_TARGET: wr_word = be_merge({8'h00, target_ff}, writedata_i, byteenable_i);
      wsc_pkg::OFF_HALF_WIN: wr_word = be_merge({8'h00, half_win_ff}, writedata_i, byteenable_i);
      wsc_pkg::OFF_DEADBAND: wr_word = be_merge({8'h00, deadband_ff}, writedata_i, byteenable_i);
      wsc_pkg::OFF_CUTOFF: wr_word = be_merge({8'h00, cutoff_ff}, writedata_i, byteenable_i);
      wsc_pkg::OFF_GAIN: wr_word = be_merge({8'h00, gain_ff}, writedata_i, byteenable_i);
      wsc_pkg::OFF_SETTLE: wr_word = be_merge({16'h0000, settle_ff}, writedata_i, byteenable_i);
      wsc_pkg::OFF_INTERVAL: wr_word = be_merge({16'h0000, interval_ff}, writedata_i, byteenable_i);
      wsc_pkg::OFF_TOL_WIN: wr_word = be_merge({8'h00, tol_ff}, writedata_i, byteenable_i);
      default: wr_word = writedata_i & {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                                        {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
    endcase
  end

  // Target, window, deadband and tolerance saturate above range; gain, settle, interval truncate
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dir_ff <= 2'h0;
      cut_ff <= 2'h0;
      kind_ff <= 2'h0;
      batch_mode_ff <= 1'b0;
      src_ff <= '0;
      target_ff <= 24'h0;
      half_win_ff <= 24'h0;
      deadband_ff <= 24'h0;
      gain_ff <= wsc_pkg::GAIN_RST;
      settle_ff <= wsc_pkg::SETTLE_RST;
      interval_ff <= wsc_pkg::INTERVAL_RST;
      tol_ff <= 24'h0;
    end else if (wr) begin
      case (address_i)
        wsc_pkg::OFF_CTRL: begin
          dir_ff <= wr_word[wsc_pkg::CTRL_DIR_POS +: 2];
          cut_ff <= wr_word[wsc_pkg::CTRL_CUT_POS +: 2];
          kind_ff <= wr_word[wsc_pkg::CTRL_KIND_POS +: 2];
          batch_mode_ff <= wr_word[wsc_pkg::CTRL_BATCH_POS];
          src_ff <= wr_word[wsc_pkg::CTRL_SRC_POS +: SRC_W];
        end
        wsc_pkg::OFF_TARGET: target_ff <= sat_val(wr_word);
        wsc_pkg::OFF_HALF_WIN: half_win_ff <= sat_val(wr_word);
        wsc_pkg::OFF_DEADBAND: deadband_ff <= sat_val(wr_word);
        wsc_pkg::OFF_GAIN: gain_ff <= wr_word[23:0];
        wsc_pkg::OFF_SETTLE: settle_ff <= wr_word[15:0];
        wsc_pkg::OFF_INTERVAL: interval_ff <= wr_word[15:0];
        wsc_pkg::OFF_TOL_WIN: tol_ff <= sat_val(wr_word);
        default: ;
      endcase
    end
  end

  // ****************************************
  // Source scale and comparison
  // ****************************************
  assign w_raw = weight_i[src_ff*32 +: 32];
  assign smp = sample_valid_i[src_ff];
  assign still = standstill_i[src_ff];
  assign w = {{2{w_raw[31]}}, w_raw};
  assign tgt = $signed({10'h000, target_ff});
  assign hw = $signed({10'h000, half_win_ff});
  assign db = $signed({10'h000, deadband_ff});
  assign cut = (cut_ff == wsc_pkg::CUT_OFF) ? 34'sh0 : $signed({10'h000, cutoff_ff});

  // Flow mode looks ahead by the last sample step, scaled
  assign w_eval = (cut_ff == wsc_pkg::CUT_FLOW) ? w + ((w - $signed({{2{prev_w_ff[31]}}, prev_w_ff})) <<< LEAD_SHIFT) : w;

  assign in_win = (w >= tgt - hw) && (w <= tgt + hw);

  always_comb begin
    met = 1'b0;
    rearm = 1'b0;
    case (kind_ff)
      wsc_pkg::KIND_TIME: begin
        met = tmr_cnt_ff >= target_ff[15:0];
        rearm = ~met;
      end
      wsc_pkg::KIND_COUNT: begin
        met = bat_cnt_ff >= target_ff[15:0];
        rearm = ~met;
      end
      default: begin
        case (dir_ff)
          wsc_pkg::DIR_ABOVE: begin
            met = w_eval >= tgt - cut;
            rearm = w < tgt - db;
          end
          wsc_pkg::DIR_BELOW: begin
            met = w_eval < tgt + cut;
            rearm = w > tgt + db;
          end
          wsc_pkg::DIR_INSIDE: begin
            met = in_win;
            rearm = (w < tgt - hw - db) || (w > tgt + hw + db);
          end
          default: begin
            met = ~in_win;
            rearm = (w > tgt - hw + db) && (w < tgt + hw - db);
          end
        endcase
      end
    endcase
  end

  // Latched trip; in batch mode a new batch re-arms so the feed can start again
  always_comb begin
    nxt_sat = sat_ff;
    if (batch_mode_ff && batch_run_i && !run_d_ff) begin
      nxt_sat = 1'b0;
    end else if (smp || kind_ff != wsc_pkg::KIND_WEIGHT) begin
      if (!sat_ff && met) begin
        nxt_sat = 1'b1;
      end else if (sat_ff && rearm) begin
        nxt_sat = 1'b0;
      end
    end
  end

  // Output follows the trip at the same edge as the sample
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sat_ff <= 1'b0;
      feed_ff <= 1'b0;
      run_d_ff <= 1'b0;
    end else begin
      sat_ff <= nxt_sat;
      run_d_ff <= batch_run_i;
      feed_ff <= batch_mode_ff ? (batch_run_i & ~nxt_sat) : nxt_sat;
    end
  end

  assign feed_o = feed_ff;
  assign satisfied_o = sat_ff;

  // Previous sample for the rate estimate
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prev_w_ff <= 32'h0;
    end else if (smp) begin
      prev_w_ff <= w_raw;
    end
  end

  // ****************************************
  // Timer and batch counters
  // ****************************************
  // Time counts only while the batch runs; saturates at 65535
  always_ff @(posedge clock_i) begin
    if (rst_i || !batch_run_i) begin
      tmr_cnt_ff <= 16'h0;
    end else if (tick && tmr_cnt_ff != wsc_pkg::CNT_MAX) begin
      tmr_cnt_ff <= tmr_cnt_ff + 16'h1;
    end
  end

  // Control write restarts the batch tally
  always_ff @(posedge clock_i) begin
    if (rst_i || (wr && address_i == wsc_pkg::OFF_CTRL)) begin
      bat_cnt_ff <= 16'h0;
    end else if (batch_done_i && bat_cnt_ff != wsc_pkg::CNT_MAX) begin
      bat_cnt_ff <= bat_cnt_ff + 16'h1;
    end
  end

  // ****************************************
  // Adaptive cutoff learning
  // ****************************************
  // Interval zero means learning never fires
  assign lrn_start = batch_done_i && cut_ff == wsc_pkg::CUT_LEARN && interval_ff != 16'h0 &&
                     lrn_cnt_ff + 16'h1 >= interval_ff;

  always_ff @(posedge clock_i) begin
    if (rst_i || cut_ff != wsc_pkg::CUT_LEARN) begin
      lrn_cnt_ff <= 16'h0;
    end else if (batch_done_i) begin
      lrn_cnt_ff <= lrn_start ? 16'h0 : lrn_cnt_ff + 16'h1;
    end
  end

  assign err = (dir_ff == wsc_pkg::DIR_BELOW) ? tgt - cap_w_ff : cap_w_ff - tgt;
  assign prod = err * $signed({1'b0, gain_ff});
  assign new_cut = $signed({10'h000, cutoff_ff}) + $signed(prod[49:16]);
  assign out_tol = tol_ff != 24'h0 && (err > $signed({10'h000, tol_ff}) ||
                   err < -$signed({10'h000, tol_ff}));
  assign lrn_apply = lstate_ff == wsc_pkg::LS_APPLY && !out_tol && dir_ff[1] == 1'b0;
  assign lrn_skip = (lstate_ff == wsc_pkg::LS_APPLY && !lrn_apply) ||
                    (lstate_ff == wsc_pkg::LS_SETTLE && !(still && smp) && settle_ff != 16'h0 &&
                     tick && settle_cnt_ff + 16'h1 >= settle_ff);

  always_comb begin
    nxt_lstate = lstate_ff;
    case (lstate_ff)
      wsc_pkg::LS_IDLE: if (lrn_start) nxt_lstate = wsc_pkg::LS_SETTLE;
      wsc_pkg::LS_SETTLE: begin
        if (still && smp) begin
          nxt_lstate = wsc_pkg::LS_APPLY;
        end else if (lrn_skip) begin
          nxt_lstate = wsc_pkg::LS_IDLE;
        end
      end
      wsc_pkg::LS_APPLY: nxt_lstate = wsc_pkg::LS_IDLE;
      default: nxt_lstate = wsc_pkg::LS_IDLE;
    endcase
  end

  // Settle count runs in ticks while waiting
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lstate_ff <= wsc_pkg::LS_IDLE;
      settle_cnt_ff <= 16'h0;
      cap_w_ff <= 34'sh0;
    end else begin
      lstate_ff <= nxt_lstate;
      if (lstate_ff != wsc_pkg::LS_SETTLE) begin
        settle_cnt_ff <= 16'h0;
      end else if (tick) begin
        settle_cnt_ff <= settle_cnt_ff + 16'h1;
      end
      if (lstate_ff == wsc_pkg::LS_SETTLE && still && smp) begin
        cap_w_ff <= w;
      end
    end
  end

  // Software write wins over a learn update in the same cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cutoff_ff <= 24'h0;
    end else if (wr && address_i == wsc_pkg::OFF_CUTOFF) begin
      cutoff_ff <= sat_val(wr_word);
    end else if (lrn_apply) begin
      if (new_cut < 34'sh0) begin
        cutoff_ff <= 24'h0;
      end else if (new_cut > $signed({10'h000, wsc_pkg::VAL_MAX})) begin
        cutoff_ff <= wsc_pkg::VAL_MAX;
      end else begin
        cutoff_ff <= new_cut[23:0];
      end
    end
  end

  // Sticky learn outcome; a new event beats a write-one clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      skip_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      if (lrn_skip) begin
        skip_ff <= 1'b1;
      end else if (wr && address_i == wsc_pkg::OFF_STATUS && wr_word[wsc_pkg::ST_SKIP]) begin
        skip_ff <= 1'b0;
      end
      if (lrn_apply) begin
        done_ff <= 1'b1;
      end else if (wr && address_i == wsc_pkg::OFF_STATUS && wr_word[wsc_pkg::ST_DONE]) begin
        done_ff <= 1'b0;
      end
    end
  end
endmodule : wsc_comparator

// ===== core/wsc_tick_div.sv
`timescale 1ns/1ps
// ****************************************
// Tenth-second tick divider
// ****************************************
module wsc_tick_div #(
  parameter int DIV = wsc_pkg::TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [31:0] cnt_ff;

  // Free-running count, one-cycle pulse at wrap
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_ff <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_ff >= 32'(DIV - 1)) begin
      cnt_ff <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule : wsc_tick_div

// ===== shared/wsc_pkg.sv
package wsc_pkg;
  // ****************************************
  // Ranges and widths
  // ****************************************
  localparam int VAL_W = 24;
  localparam int CNT_W = 16;
  localparam int GAIN_FRAC = 16;
  localparam logic [VAL_W-1:0] VAL_MAX = 24'h98967F; // 9999999
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_TARGET = 6'h04;
  localparam logic [5:0] OFF_HALF_WIN = 6'h08;
  localparam logic [5:0] OFF_DEADBAND = 6'h0C;
  localparam logic [5:0] OFF_CUTOFF = 6'h10;
  localparam logic [5:0] OFF_GAIN = 6'h14;
  localparam logic [5:0] OFF_SETTLE = 6'h18;
  localparam logic [5:0] OFF_INTERVAL = 6'h1C;
  localparam logic [5:0] OFF_TOL_WIN = 6'h20;
  localparam logic [5:0] OFF_STATUS = 6'h24;
  localparam logic [5:0] OFF_WEIGHT = 6'h28;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int CTRL_DIR_POS = 0;
  localparam int CTRL_CUT_POS = 2;
  localparam int CTRL_KIND_POS = 4;
  localparam int CTRL_BATCH_POS = 6;
  localparam int CTRL_SRC_POS = 8;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int ST_SAT = 0;
  localparam int ST_FEED = 1;
  localparam int ST_INWIN = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_SKIP = 4;
  localparam int ST_DONE = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [VAL_W-1:0] GAIN_RST = 24'h008000; // 0.5
  localparam logic [CNT_W-1:0] INTERVAL_RST = 16'h0001;
  localparam logic [CNT_W-1:0] SETTLE_RST = 16'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 100000000; // 0.1 s
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    DIR_ABOVE = 2'h0,
    DIR_BELOW = 2'h1,
    DIR_INSIDE = 2'h2,
    DIR_OUTSIDE = 2'h3
  } wsc_dir_t;

  typedef enum logic [1:0] {
    CUT_OFF = 2'h0,
    CUT_FIXED = 2'h1,
    CUT_LEARN = 2'h2,
    CUT_FLOW = 2'h3
  } wsc_cut_t;

  typedef enum logic [1:0] {
    KIND_WEIGHT = 2'h0,
    KIND_TIME = 2'h1,
    KIND_COUNT = 2'h2
  } wsc_kind_t;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_SETTLE = 2'b01,
    LS_APPLY = 2'b11
  } wsc_learn_t;
endpackage : wsc_pkg

// ===== verification/test_weight_setpoint_comparator.sv
`timescale 1ns/1ps
module test_weight_setpoint_comparator;
  // ****
  // Bench signals and block
  // ****
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic run = 1'b0;
  logic done = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, got;
  logic waitreq, feed, sat;
  logic [127:0] wt;
  logic [3:0] sv, ss;
  int err_count = 0;
  int n_checks = 0;
  // Rows: control (bit 12 restarts the batch), weight, expected trip
  int tab[22][3] = '{'{16'h1240, 16'h3E7, 0}, '{16'h1240, 16'h3E8, 1}, '{16'h1241, 16'h3E8, 0},
    '{16'h1241, 16'h3E7, 1}, '{16'h1242, 16'h3DD, 0}, '{16'h1242, 16'h3DE, 1}, '{16'h1242, 16'h3F2, 1},
    '{16'h1242, 16'h3F3, 0}, '{16'h1243, 16'h3DE, 0}, '{16'h1243, 16'h3DD, 1}, '{16'h1243, 16'h3F3, 1},
    '{16'h1244, 16'h3C9, 0}, '{16'h1244, 16'h3CA, 1}, '{16'h1245, 16'h406, 0}, '{16'h1245, 16'h405, 1},
    '{16'h1240, 16'h3E8, 1}, '{16'h240, 16'h3C0, 1}, '{16'h240, 16'h3B5, 0}, '{16'h240, 16'h3E8, 1},
    '{16'h124C, 16'h384, 0}, '{16'h24C, 16'h384, 0}, '{16'h24C, 16'h3A2, 1}};
  // 4 ns clock
  always #2 clock_i = ~clock_i;
  // Tick cut to ten cycles to keep settle waits short
  wsc_comparator #(.TICK_DIV(10)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .address_i(adr), .read_i(read_i), .write_i(write_i),
    .writedata_i(wd), .byteenable_i(4'hF), .readdata_o(rdata), .waitrequest_o(waitreq),
    .weight_i(wt), .sample_valid_i(sv), .standstill_i(ss), .batch_run_i(run),
    .batch_done_i(done), .feed_o(feed), .satisfied_o(sat));
  wsc_scale_model m (.clock_i(clock_i), .weight_o(wt), .valid_o(sv), .still_o(ss));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock_i);
    adr <= a;
    wd <= d;
    write_i <= wr;
    read_i <= !wr;
    @(posedge clock_i);
    while (waitreq !== 1'b0) @(posedge clock_i);
    got = rdata;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask : bus
  // Sample, then look once the trip edge has landed
  task automatic smp(input int k, input logic [31:0] w);
    m.put(k, w);
    @(negedge clock_i);
  endtask : smp
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    bus(1'b0, wsc_pkg::OFF_GAIN, 32'h0);
    chk(got, 32'h8000);
    bus(1'b0, wsc_pkg::OFF_INTERVAL, 32'h0);
    chk(got, 32'h1);
    bus(1'b1, wsc_pkg::OFF_TARGET, 32'hFFFFFF);
    bus(1'b0, wsc_pkg::OFF_TARGET, 32'h0);
    chk(got, 32'h98967F);
  endtask : t_regs
  // Boundaries per direction and cutoff; restart clears the trip first
  task automatic t_table();
    bus(1'b1, wsc_pkg::OFF_TARGET, 32'h3E8);
    bus(1'b1, wsc_pkg::OFF_HALF_WIN, 32'hA);
    bus(1'b1, wsc_pkg::OFF_DEADBAND, 32'h32);
    bus(1'b1, wsc_pkg::OFF_CUTOFF, 32'h1E);
    for (int i = 0; i < 22; i++) begin
      if (i == 0 || tab[i][0][11:0] != tab[i-1][0][11:0]) bus(1'b1, wsc_pkg::OFF_CTRL, tab[i][0] & 32'hFFF);
      if (tab[i][0][12]) begin
        @(posedge clock_i);
        run <= 1'b0;
        @(posedge clock_i);
        run <= 1'b1;
        smp(1, tab[i][1]);
        chk({31'h0, sat}, 32'h0);
      end
      smp(2, tab[i][1]);
      chk({30'h0, feed, sat}, {30'h0, !tab[i][2][0], tab[i][2][0]});
    end
  endtask : t_table
  // One batch end, settled sample of 1040 against target 1000
  task automatic lrn(input logic [31:0] e);
    @(posedge clock_i);
    done <= 1'b1;
    @(posedge clock_i);
    done <= 1'b0;
    smp(2, 32'h410);
    repeat (40) @(posedge clock_i);
    bus(1'b0, wsc_pkg::OFF_CUTOFF, 32'h0);
    chk(got, e);
  endtask : lrn
  task automatic t_learn();
    bus(1'b1, wsc_pkg::OFF_CTRL, 32'h248);
    bus(1'b1, wsc_pkg::OFF_CUTOFF, 32'h64);
    m.still <= 1'b1;
    lrn(32'h78);
    bus(1'b1, wsc_pkg::OFF_GAIN, 32'h10000);
    lrn(32'hA0);
    bus(1'b1, wsc_pkg::OFF_TOL_WIN, 32'hA);
    lrn(32'hA0);
    bus(1'b0, wsc_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, got[4]}, 32'h1);
    bus(1'b1, wsc_pkg::OFF_TOL_WIN, 32'h0);
    bus(1'b1, wsc_pkg::OFF_STATUS, 32'h10);
    bus(1'b0, wsc_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, got[4]}, 32'h0);
    bus(1'b1, wsc_pkg::OFF_SETTLE, 32'h2);
    m.still <= 1'b0;
    lrn(32'hA0);
    bus(1'b0, wsc_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, got[4]}, 32'h1);
  endtask : t_learn
  // Count and time kinds judge every cycle, no sample needed
  task automatic t_kinds();
    bus(1'b1, wsc_pkg::OFF_TARGET, 32'h2);
    bus(1'b1, wsc_pkg::OFF_CTRL, 32'h220);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock_i);
      done <= 1'b1;
      @(posedge clock_i);
      done <= 1'b0;
      repeat (2) @(negedge clock_i);
      chk({31'h0, sat}, i);
    end
    bus(1'b1, wsc_pkg::OFF_TARGET, 32'h3);
    bus(1'b1, wsc_pkg::OFF_CTRL, 32'h210);
    run <= 1'b0;
    @(posedge clock_i);
    run <= 1'b1;
    repeat (15) @(negedge clock_i);
    chk({31'h0, sat}, 32'h0);
    repeat (25) @(negedge clock_i);
    chk({31'h0, sat}, 32'h1);
  endtask : t_kinds
  // Main sequence after 8 cycles of reset
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    t_regs();
    t_table();
    t_learn();
    t_kinds();
    complete_run();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    complete_run();
  end
endmodule : test_weight_setpoint_comparator

// ===== verification/wsc_comparator_asserts.sv
`timescale 1ns/1ps
// ****
// Setpoint checker
// ****
module wsc_comparator_asserts #(
  parameter int NUM_SCALES = 4,
  parameter int SRC_W = 2
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [5:0] address_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic waitrequest_o,
  input wire logic [NUM_SCALES*32-1:0] weight_i,
  input wire logic [NUM_SCALES-1:0] sample_valid_i,
  input wire logic batch_run_i,
  input wire logic feed_o,
  input wire logic satisfied_o
);
  logic [31:0] regs_ff [16];
  logic run_ff, q, s;
  logic [31:0] ctl;
  int w, t, h, d, c;
  // Settings shadow, clamped like the block; learned cutoff not tracked
  always_ff @(posedge clock_i) begin
    run_ff <= batch_run_i;
    if (rst_i) begin
      regs_ff <= '{default: 32'h0};
    end else if (write_i && !waitrequest_o) begin
      regs_ff[address_i[5:2]] <= (writedata_i > 32'h98967F) ? 32'h98967F : writedata_i;
    end
  end
  // Quiet edge: weight kind, batch mode, no write, no restart
  always_comb begin
    ctl = regs_ff[0];
    w = weight_i[ctl[8+:SRC_W]*8'h20+:32];
    t = regs_ff[1];
    h = regs_ff[2];
    d = regs_ff[3];
    c = regs_ff[4];
    q = !(write_i && !waitrequest_o) && !(batch_run_i && !run_ff) && ctl[6] && ctl[5:4] == 2'h0;
    s = q && sample_valid_i[ctl[8+:SRC_W]];
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_above; s && ctl[3:0] == 4'h0 && !satisfied_o && w >= t |=> satisfied_o; endproperty
  a_above: assert property (p_above) else $error("above trip missed");
  property p_early; s && ctl[3:0] == 4'h0 && !satisfied_o && w < t |=> !satisfied_o; endproperty
  a_early: assert property (p_early) else $error("above tripped early");
  property p_below; s && ctl[3:0] == 4'h1 && !satisfied_o && w < t |=> satisfied_o; endproperty
  a_below: assert property (p_below) else $error("below trip missed");
  property p_inside; s && ctl[1:0] == 2'h2 && !satisfied_o && w >= t - h && w <= t + h |=> satisfied_o; endproperty
  a_inside: assert property (p_inside) else $error("inside trip missed");
  property p_outside; s && ctl[1:0] == 2'h3 && !satisfied_o && (w < t - h || w > t + h) |=> satisfied_o; endproperty
  a_outside: assert property (p_outside) else $error("outside trip missed");
  property p_fix_hi; s && ctl[3:0] == 4'h4 && !satisfied_o && w >= t - c |=> satisfied_o && !feed_o; endproperty
  a_fix_hi: assert property (p_fix_hi) else $error("fixed cutoff above missed");
  property p_fix_lo; s && ctl[3:0] == 4'h5 && !satisfied_o && w < t + c |=> satisfied_o; endproperty
  a_fix_lo: assert property (p_fix_lo) else $error("fixed cutoff below missed");
  property p_hold; s && ctl[1:0] == 2'h0 && ctl[3:2] != 2'h3 && satisfied_o && w >= t - d |=> satisfied_o; endproperty
  a_hold: assert property (p_hold) else $error("rearmed inside deadband");
  property p_src; q && !sample_valid_i[ctl[8+:SRC_W]] |=> $stable(satisfied_o); endproperty
  a_src: assert property (p_src) else $error("trip moved without a sample");
  property p_feed; ctl[6] && ctl[5:4] == 2'h0 && run_ff && $stable(ctl) |-> feed_o == !satisfied_o; endproperty
  a_feed: assert property (p_feed) else $error("feed not cut at trip");
  c_trip: cover property (s && !satisfied_o ##1 satisfied_o);
  c_rearm: cover property (s && satisfied_o ##1 !satisfied_o);
  c_flow: cover property (s && ctl[3:2] == 2'h3 ##1 satisfied_o);
endmodule : wsc_comparator_asserts

bind wsc_comparator wsc_comparator_asserts #(.NUM_SCALES(NUM_SCALES), .SRC_W(SRC_W)) u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .write_i(write_i), .writedata_i(writedata_i),
  .waitrequest_o(waitrequest_o), .weight_i(weight_i), .sample_valid_i(sample_valid_i),
  .batch_run_i(batch_run_i), .feed_o(feed_o), .satisfied_o(satisfied_o));

// ===== verification/wsc_scale_model.sv
`timescale 1ns/1ps
// ****
// Scale source model
// ****
module wsc_scale_model #(
  parameter int N = 4
) (
  input wire logic clock_i,
  output logic [N*32-1:0] weight_o,
  output logic [N-1:0] valid_o,
  output logic [N-1:0] still_o
);
  logic still = 1'b0;
  // Standstill shared by all scales
  assign still_o = {N{still}};
  // Quiet bus at time zero
  initial begin
    weight_o = {N{32'h0}};
    valid_o = {N{1'b0}};
  end
  // One sample; idle scales show the inverse, so a wrong pick shows
  task automatic put(input int k, input logic [31:0] w);
    logic [N*32-1:0] v;
    v = {N{~w}};
    v[k*32+:32] = w;
    @(posedge clock_i);
    weight_o <= v;
    valid_o <= {{(N-1){1'b0}}, 1'b1} << k;
    @(posedge clock_i);
    valid_o <= {N{1'b0}};
  endtask : put
endmodule : wsc_scale_model
